// ==== rtl/dhcs_pkg.sv ====
// Purpose: shared constants for the dual host control select block
// Assumes: one 40 MHz clock, classic wishbone register access
// Notes: legacy select codes are the bit-inverted ones seen at the decoder
package dhcs_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // command codes seen at the decoder (nominal 6 and 7, lines inverted)
   localparam logic [3:0] CODE_LEGACY = 4'h9;
   localparam logic [3:0] CODE_ARRAY = 4'h8;
   // register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   // control register fields
   localparam int unsigned CTRL_OVR_BIT = 0;
   localparam int unsigned CTRL_WID_LSB = 4;
   localparam int unsigned WID_W = 4;
   localparam logic [3:0] WID_RESET = 4'h4;
   localparam logic [3:0] WID_MIN = 4'h2;
   // status register fields
   localparam int unsigned ST_HOSTCTL_BIT = 0;
   localparam int unsigned ST_BUSY_ACKNOWLEDGE_BIT = 1;
   localparam int unsigned ST_ARRLIT_BIT = 2;
   localparam int unsigned ST_LEGLIT_BIT = 3;
   localparam int unsigned ST_CNT_LSB = 8;
   localparam int unsigned CNT_W = 8;
   // bus and data widths
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned CMD_W = 4;
   localparam int unsigned PIN_W = 8;
   typedef enum logic [1:0] {
      DHCS_PG_IDLE,
      DHCS_PG_LOW
   } dhcs_pg_state_t;
endpackage

// ==== rtl/dhcs_pulse_gen.sv ====
// Purpose: programmable-width active-low pulse on each trigger taken while idle
// Assumes: trigger is a one-cycle pulse on clk_i
// Notes: widths under the minimum are raised to it
module dhcs_pulse_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   dhcs_pulse_if.gen pif
);
   dhcs_pkg::dhcs_pg_state_t state_ff;
   dhcs_pkg::dhcs_pg_state_t nxt_state;
   logic [dhcs_pkg::WID_W-1:0] cnt_ff;
   logic [dhcs_pkg::WID_W-1:0] nxt_cnt;
   logic pulse_n_ff;
   logic [dhcs_pkg::WID_W-1:0] eff_width;

   // retrigger during a pulse is ignored; the busy handshake forbids it anyway
   assign eff_width = (pif.width < dhcs_pkg::WID_MIN) ? dhcs_pkg::WID_MIN : pif.width;
   assign pif.pulse_n = pulse_n_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         dhcs_pkg::DHCS_PG_IDLE: begin
            if (pif.trigger) begin
               nxt_state = dhcs_pkg::DHCS_PG_LOW;
               nxt_cnt = eff_width - 4'h1;
            end
         end
         dhcs_pkg::DHCS_PG_LOW: begin
            if (cnt_ff == 4'h0) begin
               nxt_state = dhcs_pkg::DHCS_PG_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         default: begin
            nxt_state = dhcs_pkg::DHCS_PG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= dhcs_pkg::DHCS_PG_IDLE;
         cnt_ff <= 4'h0;
         pulse_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         pulse_n_ff <= (nxt_state != dhcs_pkg::DHCS_PG_LOW);
      end
   end
endmodule

// ==== rtl/dhcs_pulse_if.sv ====
// Purpose: carrier between the top and the setup pulse generator
// Assumes: all signals on clk_i
// Notes: pulse_n is active low
interface dhcs_pulse_if;
   logic trigger;
   logic [dhcs_pkg::WID_W-1:0] width;
   logic pulse_n;
   modport master (output trigger, output width, input pulse_n);
   modport gen (input trigger, input width, output pulse_n);
endinterface

// ==== rtl/dhcs_top.sv ====
// Purpose: host arbitration and strobe generation for two hosts
// Assumes: pins are asynchronous and pass two flops; block read pulse is on clk_i
// Notes: combinational paths of the original are one to five cycles later here
module dhcs_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [dhcs_pkg::CMD_W-1:0] legacy_command_lines_i,
   input wire logic legacy_setup_strobe_n_i,
   input wire logic legacy_read_strobe_n_i,
   input wire logic host_bus_master_strobe_i,
   input wire logic host_command_qualifier_i,
   input wire logic block_read_pulse_n_i,
   input wire logic [dhcs_pkg::DATA_W-1:0] legacy_data_i,
   input wire logic [dhcs_pkg::DATA_W-1:0] host_data_i,
   input wire logic [dhcs_pkg::CMD_W-1:0] legacy_cmd_i,
   input wire logic [dhcs_pkg::CMD_W-1:0] host_cmd_i,
   input wire logic [dhcs_pkg::ADDR_W-1:0] legacy_addr_i,
   input wire logic [dhcs_pkg::ADDR_W-1:0] host_addr_i,
   output logic [dhcs_pkg::DATA_W-1:0] selected_data_out_o,
   output logic [dhcs_pkg::CMD_W-1:0] selected_command_out_o,
   output logic [dhcs_pkg::ADDR_W-1:0] buffer_addr_o,
   output logic host_control_o,
   output logic legacy_control_indicator_n_o,
   output logic array_control_indicator_n_o,
   output logic master_setup_strobe_n_o,
   output logic busy_acknowledge_n_o,
   output logic block_read_trigger_n_o,
   output logic toggle_read_trigger_n_o,
   output logic master_read_strobe_n_o
);
   // pin synchronisers: stage one is read only by stage two
   logic [dhcs_pkg::PIN_W-1:0] pin_raw;
   logic [dhcs_pkg::PIN_W-1:0] pin_s1_ff;
   logic [dhcs_pkg::PIN_W-1:0] pin_s2_ff;
   logic [dhcs_pkg::CMD_W-1:0] cmd_s;
   logic setup_n_s;
   logic read_n_s;
   logic host_bus_master_strobe_s;
   logic qual_s;

   assign pin_raw = {host_command_qualifier_i, host_bus_master_strobe_i,
                     legacy_read_strobe_n_i, legacy_setup_strobe_n_i,
                     legacy_command_lines_i};
   assign cmd_s = pin_s2_ff[3:0];
   assign setup_n_s = pin_s2_ff[4];
   assign read_n_s = pin_s2_ff[5];
   assign host_bus_master_strobe_s = pin_s2_ff[6];
   assign qual_s = pin_s2_ff[dhcs_pkg::PIN_W-1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_ff <= 8'h30;
         pin_s2_ff <= 8'h30;
      end else begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // registers of the wishbone slave
   logic override_ff;
   logic [dhcs_pkg::WID_W-1:0] width_ff;
   logic [dhcs_pkg::CNT_W-1:0] setup_cnt_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic wb_req;
   logic wr_ctrl;
   logic hit_ctrl;
   logic hit_status;
   logic [31:0] rd_mux;

   // decoder: four select inputs, setup strobe acts as active-low enable
   logic dec_legacy;
   logic dec_array;
   logic dec_array_prev_ff;
   logic sel_ff;
   logic host_ctl;

   assign dec_legacy = ~setup_n_s & (cmd_s == dhcs_pkg::CODE_LEGACY);
   assign dec_array = ~setup_n_s & (cmd_s == dhcs_pkg::CODE_ARRAY);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_ff <= 1'b0;
         dec_array_prev_ff <= 1'b0;
      end else begin
         dec_array_prev_ff <= dec_array;
         if (dec_legacy) begin
            sel_ff <= 1'b0;
         end else if (dec_array & ~dec_array_prev_ff) begin
            sel_ff <= 1'b1;
         end
      end
   end

   assign host_ctl = sel_ff & ~override_ff;

   // strobe derivation from bus-master and qualifier
   logic dsetup_n;
   logic dread_n;
   logic dsetup_n_prev_ff;
   logic host_bus_master_strobe_prev_ff;
   logic host_bus_master_strobe_fall;

   assign dsetup_n = ~(host_bus_master_strobe_s & qual_s);
   assign dread_n = ~(host_bus_master_strobe_s & ~qual_s);
   assign host_bus_master_strobe_fall = host_bus_master_strobe_prev_ff & ~host_bus_master_strobe_s;

   dhcs_pulse_if pif ();
   assign pif.trigger = dsetup_n_prev_ff & ~dsetup_n;
   assign pif.width = width_ff;

   dhcs_pulse_gen u_pulse (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pif(pif)
   );

   // busy flop: release on bus-master drop dominates, as a direct set would
   logic busy_n_ff;
   logic blk_prev_ff;
   logic blk_fall;
   assign blk_fall = blk_prev_ff & ~block_read_pulse_n_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_n_ff <= 1'b1;
         dsetup_n_prev_ff <= 1'b1;
         host_bus_master_strobe_prev_ff <= 1'b0;
         blk_prev_ff <= 1'b1;
      end else begin
         dsetup_n_prev_ff <= dsetup_n;
         host_bus_master_strobe_prev_ff <= host_bus_master_strobe_s;
         blk_prev_ff <= block_read_pulse_n_i;
         if (~host_bus_master_strobe_s) begin
            busy_n_ff <= 1'b1;
         end else if (~pif.pulse_n) begin
            busy_n_ff <= 1'b0;
         end else if (blk_fall) begin
            busy_n_ff <= 1'b0;
         end
      end
   end

   // merged strobes and selected paths, all registered
   logic master_setup_n;
   assign master_setup_n = pif.pulse_n & setup_n_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         selected_data_out_o <= 16'h0000;
         selected_command_out_o <= 4'h0;
         buffer_addr_o <= 12'h000;
         host_control_o <= 1'b0;
         legacy_control_indicator_n_o <= 1'b0;
         array_control_indicator_n_o <= 1'b1;
         master_setup_strobe_n_o <= 1'b1;
         busy_acknowledge_n_o <= 1'b1;
         block_read_trigger_n_o <= 1'b1;
         toggle_read_trigger_n_o <= 1'b1;
         master_read_strobe_n_o <= 1'b1;
         setup_cnt_ff <= 8'h00;
      end else begin
         selected_data_out_o <= host_ctl ? host_data_i : legacy_data_i;
         selected_command_out_o <= host_ctl ? host_cmd_i : legacy_cmd_i;
         buffer_addr_o <= host_ctl ? host_addr_i : legacy_addr_i;
         host_control_o <= host_ctl;
         legacy_control_indicator_n_o <= host_ctl;
         array_control_indicator_n_o <= ~sel_ff | override_ff;
         master_setup_strobe_n_o <= master_setup_n;
         busy_acknowledge_n_o <= busy_n_ff;
         block_read_trigger_n_o <= dread_n;
         toggle_read_trigger_n_o <= dread_n;
         master_read_strobe_n_o <= dread_n & read_n_s;
         // load count shows each master setup strobe reaching the setup registers
         if (master_setup_strobe_n_o & ~master_setup_n) begin
            setup_cnt_ff <= setup_cnt_ff + 8'h01;
         end
      end
   end

   // wishbone slave: ack one cycle after request, dropped the cycle after
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign hit_ctrl = (wb_adr_i == dhcs_pkg::ADDR_CTRL);
   assign hit_status = (wb_adr_i == dhcs_pkg::ADDR_STATUS);
   assign wr_ctrl = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];
   assign rd_mux = hit_ctrl ? {24'h000000, width_ff, 3'h0, override_ff} :
                   hit_status ? {16'h0000, setup_cnt_ff, 4'h0,
                                 legacy_control_indicator_n_o, array_control_indicator_n_o,
                                 busy_n_ff, host_ctl} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
         override_ff <= 1'b0;
         width_ff <= dhcs_pkg::WID_RESET;
      end else begin
         ack_ff <= wb_req;
         if (wb_req & ~wb_we_i) begin
            dat_ff <= rd_mux;
         end
         if (wr_ctrl) begin
            override_ff <= wb_dat_i[dhcs_pkg::CTRL_OVR_BIT];
            width_ff <= wb_dat_i[dhcs_pkg::CTRL_WID_LSB +: dhcs_pkg::WID_W];
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
endmodule

// ==== sim/dhcs_ap_model.sv ====
// Purpose: array processor host on the bus-master handshake
// Assumes: outputs change by non-blocking assignment after a rising edge
// Notes: qualifier shows the inverse level once bus-master is released
module dhcs_ap_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic qual_i,
   input wire logic [3:0] hold_i,
   input wire logic busy_n_i,
   output logic host_bus_master_strobe_o,
   output logic qual_o,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int n;
   initial begin
      host_bus_master_strobe_o = 1'b0;
      qual_o = 1'b1;
      done_o = 1'b0;
      forever begin
         @(posedge clk_i);
         done_o <= 1'b0;
         if (go_i === 1'b1) begin
            host_bus_master_strobe_o <= 1'b1;
            qual_o <= qual_i;
            n = 0;
            // bounded so a silent device cannot hang the host
            while (busy_n_i !== 1'b0 && n < 64) begin
               @(posedge clk_i);
               n++;
            end
            repeat (hold_i) @(posedge clk_i);
            host_bus_master_strobe_o <= 1'b0;
            qual_o <= ~qual_i;
            repeat (6) @(posedge clk_i);
            done_o <= 1'b1;
         end
      end
   end
endmodule

// ==== sim/dhcs_tb_top.sv ====
// Purpose: self-checking bench for the dual host control select top
// Assumes: 40 MHz clock, wishbone ack one cycle after the taking edge
// Notes: far side is the array processor model plus legacy pins
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dhcs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, go = 1'b0, qual = 1'b0;
   logic ls_n = 1'b1, bl_n = 1'b1, saw_busy = 1'b0, host_bus_master_strobe, hq, done;
   logic ack, hc, lli, ali, msn, busy_n, btr, ttr, mrs;
   logic [3:0] adr = 4'h0, cmd = 4'hF, hold = 4'h0, lcm = 4'h0, hcm = 4'h0, sco;
   logic [3:0] ms_cnt = 4'h0, ms_w = 4'h0;
   logic [15:0] ld = 16'h0, hd = 16'h0, sdo;
   logic [11:0] la = 12'h0, ha = 12'h0, bao;
   logic [31:0] dat = 32'h0, rd, dat_o;
   int errors = 0, samples_checked = 0, cycles = 0;
   always #12.5 clk_i = ~clk_i;
   dhcs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .legacy_command_lines_i(cmd), .legacy_setup_strobe_n_i(ls_n),
      .legacy_read_strobe_n_i(1'b1), .host_bus_master_strobe_i(host_bus_master_strobe),
      .host_command_qualifier_i(hq), .block_read_pulse_n_i(bl_n), .legacy_data_i(ld),
      .host_data_i(hd), .legacy_cmd_i(lcm), .host_cmd_i(hcm), .legacy_addr_i(la),
      .host_addr_i(ha), .selected_data_out_o(sdo), .selected_command_out_o(sco),
      .buffer_addr_o(bao), .host_control_o(hc), .legacy_control_indicator_n_o(lli),
      .array_control_indicator_n_o(ali), .master_setup_strobe_n_o(msn),
      .busy_acknowledge_n_o(busy_n), .block_read_trigger_n_o(btr),
      .toggle_read_trigger_n_o(ttr), .master_read_strobe_n_o(mrs));
   dhcs_ap_model ap (.clk_i(clk_i), .go_i(go), .qual_i(qual), .hold_i(hold),
      .busy_n_i(busy_n), .host_bus_master_strobe_o(host_bus_master_strobe), .qual_o(hq), .done_o(done));
   always @(posedge clk_i) begin
      if (busy_n === 1'b0) saw_busy <= 1'b1;
      ms_cnt <= (msn === 1'b0) ? ms_cnt + 4'h1 : 4'h0;
      if (msn === 1'b1 && ms_cnt != 4'h0) ms_w <= ms_cnt;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         give_verdict;
      end
   end
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) errors++;
      rd = dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic leg(input logic [3:0] c, input logic e);
      cmd <= c;
      ls_n <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK(msn, 1'b0)
      ls_n <= 1'b1;
      cmd <= ~c;
      repeat (8) @(posedge clk_i);
      `CHK(hc, e)
   endtask
   task automatic start(input logic q, input logic [3:0] h);
      saw_busy = 1'b0;
      qual <= q;
      hold <= h;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      if (done !== 1'b1) errors++;
   endtask
   task automatic t_regs;
      wb(1'b0, dhcs_pkg::ADDR_CTRL, 32'h0);
      `CHK(rd, 32'(dhcs_pkg::WID_RESET) << dhcs_pkg::CTRL_WID_LSB)
      wb(1'b1, dhcs_pkg::ADDR_STATUS, 32'hF);
      wb(1'b0, dhcs_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[3:0], 4'h6)
      wb(1'b1, 4'h8, 32'hFF);
      wb(1'b0, 4'h8, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   task automatic t_select;
      leg(4'h8, 1'b1);
      leg(4'h7, 1'b1);
      leg(4'h6, 1'b1);
      leg(4'h9, 1'b0);
      leg(4'h7, 1'b0);
      leg(4'h8, 1'b1);
      {ld, hd, la, ha, lcm, hcm} <= {16'h1234, 16'hBEEF, 12'h0A5, 12'hF5A, 4'h3, 4'hC};
      repeat (4) @(posedge clk_i);
      `CHK({sdo, sco, bao}, {16'hBEEF, 4'hC, 12'hF5A})
      wb(1'b1, dhcs_pkg::ADDR_CTRL, 32'h41);
      repeat (5) @(posedge clk_i);
      `CHK({hc, lli, ali, sdo, bao}, {3'b001, 16'h1234, 12'h0A5})
      wb(1'b1, dhcs_pkg::ADDR_CTRL, 32'h40);
      repeat (5) @(posedge clk_i);
      `CHK({hc, lli, ali}, 3'b110)
   endtask
   task automatic t_setup(input logic [3:0] w);
      wb(1'b1, dhcs_pkg::ADDR_CTRL, 32'(w) << dhcs_pkg::CTRL_WID_LSB);
      start(1'b1, w);
      wait_done;
      `CHK(ms_w, (w < dhcs_pkg::WID_MIN) ? dhcs_pkg::WID_MIN : w)
      `CHK({saw_busy, busy_n, btr}, 3'b111)
   endtask
   task automatic t_read;
      start(1'b0, 4'h2);
      repeat (7) @(posedge clk_i);
      `CHK({btr, ttr, mrs, msn, busy_n}, 5'b00011)
      bl_n <= 1'b0;
      @(posedge clk_i);
      bl_n <= 1'b1;
      wait_done;
      `CHK({saw_busy, busy_n, btr, ttr}, 4'b1111)
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_regs;
      t_select;
      t_setup(4'h1);
      t_setup(4'h3);
      t_setup(4'h6);
      t_read;
      give_verdict;
   end
endmodule

// ==== sim/dhcs_top_asserts.sv ====
// Purpose: port checks for the dual host control select top
// Assumes: one clock, synchronous active-high reset
// Notes: pin inputs pass sync flops, so windows are ranges
module dhcs_top_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic legacy_setup_strobe_n_i,
   input wire logic host_bus_master_strobe_i,
   input wire logic host_command_qualifier_i,
   input wire logic block_read_pulse_n_i,
   input wire logic host_control_o,
   input wire logic legacy_control_indicator_n_o,
   input wire logic array_control_indicator_n_o,
   input wire logic master_setup_strobe_n_o,
   input wire logic busy_acknowledge_n_o,
   input wire logic block_read_trigger_n_o,
   input wire logic toggle_read_trigger_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] idle_ff, nxt_idle, rd_ff, nxt_rd;
   // saturating run lengths, so long waits need no long repetition
   assign nxt_idle = host_bus_master_strobe_i ? 4'h0 : idle_ff + {3'h0, idle_ff != 4'hF};
   assign nxt_rd = (host_bus_master_strobe_i && !host_command_qualifier_i) ?
      rd_ff + {3'h0, rd_ff != 4'hF} : 4'h0;
   always_ff @(posedge clk_i) begin
      idle_ff <= rst_i ? 4'h0 : nxt_idle;
      rd_ff <= rst_i ? 4'h0 : nxt_rd;
   end
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   chk_legacy_lamp: assert property ($stable(host_control_o) [*2] |->
      legacy_control_indicator_n_o == host_control_o) else $error("legacy lamp");
   chk_array_lamp: assert property ($stable(host_control_o) [*2] |->
      array_control_indicator_n_o == !host_control_o) else $error("array lamp");
   chk_idle_strobes: assert property (idle_ff >= 4'h5 |->
      block_read_trigger_n_o && toggle_read_trigger_n_o) else $error("idle strobe");
   chk_busy_release: assert property (idle_ff >= 4'h6 |-> busy_acknowledge_n_o)
      else $error("busy held");
   chk_read_strobe: assert property (rd_ff >= 4'h6 |-> !block_read_trigger_n_o)
      else $error("read strobe");
   chk_read_pair: assert property (block_read_trigger_n_o == toggle_read_trigger_n_o)
      else $error("read pair");
   chk_pulse_width: assert property ($fell(master_setup_strobe_n_o) |=>
      !master_setup_strobe_n_o) else $error("short pulse");
   chk_busy_clear: assert property ($rose(host_bus_master_strobe_i) &&
      host_command_qualifier_i |-> ##[3:8] !busy_acknowledge_n_o) else $error("no busy");
   chk_block_busy: assert property ($fell(block_read_pulse_n_i) &&
      host_bus_master_strobe_i |-> ##[1:4] !busy_acknowledge_n_o) else $error("no busy");
   chk_legacy_merge: assert property ($fell(legacy_setup_strobe_n_i) |->
      ##[2:6] !master_setup_strobe_n_o) else $error("no merge");
   cov_ack: cover property (wb_ack_o);
   cov_setup: cover property ($fell(busy_acknowledge_n_o) && host_command_qualifier_i);
   cov_read: cover property ($fell(block_read_trigger_n_o));
endmodule

bind dhcs_top dhcs_top_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .legacy_setup_strobe_n_i, .host_bus_master_strobe_i, .host_command_qualifier_i,
   .block_read_pulse_n_i, .host_control_o, .legacy_control_indicator_n_o,
   .array_control_indicator_n_o, .master_setup_strobe_n_o, .busy_acknowledge_n_o,
   .block_read_trigger_n_o, .toggle_read_trigger_n_o);
